//--- shared/mbt_consts.svh
// Constants for the register-serial command interpreter
`ifndef MBT_CONSTS_SVH
`define MBT_CONSTS_SVH
`define MBT_FN_READ 8'h03
`define MBT_FN_WRITE 8'h06
`define MBT_REG_ADDR 16'h0000
`define MBT_REG_BAUD 16'h0001
`define MBT_REG_UNIT 16'h0002
`define MBT_REG_DEC 16'h0003
`define MBT_REG_PV 16'h0004
`define MBT_REG_ZERO_OFS 16'h000C
`define MBT_REG_SAVE 16'h000F
`define MBT_REG_RESTORE 16'h0010
`define MBT_BYTE_CNT 8'h02
`define MBT_CRC_POLY 16'hA001
`define MBT_CRC_INIT 16'hFFFF
`define MBT_RST_ADDR 8'h01
`define MBT_RST_BAUD 3'h3
`define MBT_RST_DEC 2'h3
`define MBT_RST_OFS 16'h0000
`define MBT_SAVE_USER 16'h0000
`define MBT_SAVE_FACT 16'h0001
`define MBT_RESTORE_GO 16'h0001
`define MBT_ABN_CODE 16'h8000
`define MBT_REQ_LEN 4'h8
`define MBT_RD_RSP_LEN 4'h7
`define MBT_IDX_W 4
`endif

//--- shared/mbt_pkg.sv
// Types for the register-serial command interpreter
package mbt_pkg;
	typedef enum logic [3:0] {
		MBT_IDLE = 4'b0001,
		MBT_CHECK = 4'b0010,
		MBT_REPLY = 4'b0100,
		MBT_APPLY = 4'b1000
	} mbt_state_e;
	typedef struct packed {
		logic [7:0] addr;
		logic [2:0] baud;
		logic [15:0] zero_ofs;
	} mbt_params_s;
endpackage

//--- hw/mbt_frame_buf.sv
// Small byte memory holding one frame
`timescale 1ns/1ps
module mbt_frame_buf #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock
	input wire logic sys_clk_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_idx_i,
	input wire logic [7:0] wr_data_i,
	// Read port
	input wire logic [AW-1:0] rd_idx_i,
	output logic [7:0] rd_data_o
);
	logic [7:0] mem_ff [DEPTH];
	logic [7:0] rd_data_ff;
	always_ff @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			mem_ff[wr_idx_i] <= wr_data_i;
		end
		rd_data_ff <= mem_ff[rd_idx_i];
	end
	assign rd_data_o = rd_data_ff;
endmodule // mbt_frame_buf

//--- hw/mbt_cmd_top.sv
// Command interpreter of the serial transmitter slave
`timescale 1ns/1ps
`include "mbt_consts.svh"
module mbt_cmd_top
	import mbt_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Received bytes from the UART
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_gap_i,
	// Transmit bytes to the UART
	input wire logic tx_ready_i,
	input wire logic tx_done_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	// Measurement and non-volatile side
	input wire logic [15:0] meas_i,
	input wire logic [1:0] dec_places_i,
	input wire logic [15:0] unit_i,
	input wire mbt_params_s fact_params_i,
	output logic [2:0] baud_code_o,
	output logic [7:0] bus_addr_o,
	output logic save_user_o,
	output logic save_fact_o,
	output logic restore_o,
	output logic cal_abnormal_o
);
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `MBT_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	mbt_state_e st_ff, nxt_st;
	mbt_params_s act_ff, nxt_act, pend_ff, nxt_pend;
	logic [3:0] idx_ff, nxt_idx;
	logic [15:0] crc_ff, nxt_crc;
	logic [7:0] req_ff [8];
	logic [7:0] nxt_req [8];
	logic rd_rsp_ff, nxt_rd_rsp;
	logic [15:0] rd_val_ff, nxt_rd_val;
	logic tx_valid_ff, nxt_tx_valid;
	logic [7:0] tx_data_ff, nxt_tx_data;
	logic save_u_ff, nxt_save_u, save_f_ff, nxt_save_f, rest_ff, nxt_rest;
	logic abn_ff, nxt_abn;
	logic [7:0] buf_rd;
	logic [15:0] reg_sel, wr_val;

	mbt_frame_buf #(.DEPTH(8), .AW(3)) u_buf (
		.sys_clk_i(sys_clk_i),
		.wr_en_i(rx_valid_i && st_ff == MBT_IDLE && idx_ff < `MBT_REQ_LEN),
		.wr_idx_i(idx_ff[2:0]),
		.wr_data_i(rx_data_i),
		.rd_idx_i(idx_ff[2:0]),
		.rd_data_o(buf_rd)
	);

	assign reg_sel = {req_ff[2], req_ff[3]};
	assign wr_val = {req_ff[4], req_ff[5]};

	always_comb begin
		nxt_st = st_ff;
		nxt_act = act_ff;
		nxt_pend = pend_ff;
		nxt_idx = idx_ff;
		nxt_crc = crc_ff;
		nxt_req = req_ff;
		nxt_rd_rsp = rd_rsp_ff;
		nxt_rd_val = rd_val_ff;
		nxt_tx_valid = 1'b0;
		nxt_tx_data = tx_data_ff;
		nxt_save_u = 1'b0;
		nxt_save_f = 1'b0;
		nxt_rest = 1'b0;
		nxt_abn = abn_ff;
		case (st_ff)
			MBT_IDLE: begin
				if (rx_gap_i) begin
					nxt_idx = 4'h0;
					// Running CRC must survive into the check
					if (idx_ff == `MBT_REQ_LEN) begin
						nxt_st = MBT_CHECK;
					end else begin
						nxt_crc = `MBT_CRC_INIT;
					end
				end else if (rx_valid_i && idx_ff < `MBT_REQ_LEN) begin
					nxt_req[idx_ff[2:0]] = rx_data_i;
					nxt_idx = idx_ff + 4'h1;
					if (idx_ff < 4'h6) begin
						nxt_crc = crc_byte(crc_ff, rx_data_i);
					end
				end else if (rx_valid_i) begin
					// Overlong frame is spoiled
					nxt_idx = 4'hF;
				end
			end
			MBT_CHECK: begin
				nxt_st = MBT_IDLE;
				nxt_crc = `MBT_CRC_INIT;
				if ({req_ff[7], req_ff[6]} == crc_ff && req_ff[0] == act_ff.addr) begin
					nxt_pend = act_ff;
					nxt_rd_rsp = 1'b0;
					if (req_ff[1] == `MBT_FN_READ) begin
						nxt_rd_rsp = 1'b1;
						nxt_st = MBT_REPLY;
						nxt_crc = crc_byte(crc_byte(`MBT_CRC_INIT, req_ff[0]), req_ff[1]);
						nxt_crc = crc_byte(nxt_crc, `MBT_BYTE_CNT);
						case (reg_sel)
							`MBT_REG_ADDR: nxt_rd_val = {8'h00, act_ff.addr};
							`MBT_REG_BAUD: nxt_rd_val = {13'h0000, act_ff.baud};
							`MBT_REG_UNIT: nxt_rd_val = unit_i;
							`MBT_REG_DEC: nxt_rd_val = {14'h0000, dec_places_i};
							`MBT_REG_PV: nxt_rd_val = abn_ff ? `MBT_ABN_CODE :
								meas_i + act_ff.zero_ofs;
							`MBT_REG_ZERO_OFS: nxt_rd_val = act_ff.zero_ofs;
							default: nxt_rd_val = 16'h0000;
						endcase
					end else if (req_ff[1] == `MBT_FN_WRITE) begin
						nxt_st = MBT_REPLY;
						case (reg_sel)
							`MBT_REG_ADDR: nxt_pend.addr = req_ff[5];
							`MBT_REG_BAUD: nxt_pend.baud = req_ff[5][2:0];
							`MBT_REG_ZERO_OFS: nxt_pend.zero_ofs = wr_val;
							`MBT_REG_SAVE: begin
								nxt_save_u = wr_val == `MBT_SAVE_USER;
								nxt_save_f = wr_val == `MBT_SAVE_FACT;
							end
							`MBT_REG_RESTORE: if (wr_val == `MBT_RESTORE_GO) begin
								nxt_rest = 1'b1;
								nxt_pend = fact_params_i;
								nxt_abn = 1'b0;
							end
							default: nxt_abn = 1'b1;
						endcase
					end
				end
			end
			MBT_REPLY: begin
				if (tx_ready_i && !tx_valid_ff) begin
					nxt_tx_valid = 1'b1;
					nxt_idx = idx_ff + 4'h1;
					if (rd_rsp_ff) begin
						case (idx_ff)
							4'h0: nxt_tx_data = req_ff[0];
							4'h1: nxt_tx_data = req_ff[1];
							4'h2: nxt_tx_data = `MBT_BYTE_CNT;
							4'h3: nxt_tx_data = rd_val_ff[15:8];
							4'h4: nxt_tx_data = rd_val_ff[7:0];
							4'h5: nxt_tx_data = crc_ff[7:0];
							default: nxt_tx_data = crc_ff[15:8];
						endcase
						if (idx_ff == 4'h3 || idx_ff == 4'h4) begin
							nxt_crc = crc_byte(crc_ff, nxt_tx_data);
						end
						if (idx_ff == `MBT_RD_RSP_LEN - 4'h1) begin
							nxt_st = MBT_APPLY;
						end
					end else begin
						// exact echo
						// Buffer read lags the index; byte spacing hides it
						nxt_tx_data = buf_rd;
						if (idx_ff == `MBT_REQ_LEN - 4'h1) begin
							nxt_st = MBT_APPLY;
						end
					end
				end
			end
			MBT_APPLY: begin
				if (tx_done_i) begin
					nxt_act = pend_ff;
					nxt_idx = 4'h0;
					nxt_crc = `MBT_CRC_INIT;
					nxt_st = MBT_IDLE;
				end
			end
			default: nxt_st = MBT_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff <= MBT_IDLE;
			act_ff <= '{`MBT_RST_ADDR, `MBT_RST_BAUD, `MBT_RST_OFS};
			pend_ff <= '{`MBT_RST_ADDR, `MBT_RST_BAUD, `MBT_RST_OFS};
			idx_ff <= 4'h0;
			crc_ff <= `MBT_CRC_INIT;
			req_ff <= '{default: 8'h00};
			rd_rsp_ff <= 1'b0;
			rd_val_ff <= 16'h0000;
			tx_valid_ff <= 1'b0;
			tx_data_ff <= 8'h00;
			save_u_ff <= 1'b0;
			save_f_ff <= 1'b0;
			rest_ff <= 1'b0;
			abn_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			act_ff <= nxt_act;
			pend_ff <= nxt_pend;
			idx_ff <= nxt_idx;
			crc_ff <= nxt_crc;
			req_ff <= nxt_req;
			rd_rsp_ff <= nxt_rd_rsp;
			rd_val_ff <= nxt_rd_val;
			tx_valid_ff <= nxt_tx_valid;
			tx_data_ff <= nxt_tx_data;
			save_u_ff <= nxt_save_u;
			save_f_ff <= nxt_save_f;
			rest_ff <= nxt_rest;
			abn_ff <= nxt_abn;
		end
	end

	// volatile until save pulse; framing lives in the UART
	assign tx_valid_o = tx_valid_ff;
	assign tx_data_o = tx_data_ff;
	assign baud_code_o = act_ff.baud;
	assign bus_addr_o = act_ff.addr;
	assign save_user_o = save_u_ff;
	assign save_fact_o = save_f_ff;
	assign restore_o = rest_ff;
	assign cal_abnormal_o = abn_ff;
endmodule // mbt_cmd_top

//--- verif/mbt_cmd_top_properties.sv
// Port timing checker of the command interpreter
`timescale 1ns/1ps
module mbt_cmd_chk (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Watched ports
	input wire logic tx_ready_i,
	input wire logic tx_done_i,
	input wire logic tx_valid_o,
	input wire logic [2:0] baud_code_o,
	input wire logic [7:0] bus_addr_o,
	input wire logic save_user_o,
	input wire logic save_fact_o,
	input wire logic restore_o,
	input wire logic cal_abnormal_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Reply just finished
	sequence s_done;
		$past(tx_done_i) || $past(tx_done_i, 2);
	endsequence
	property p_addr; $changed(bus_addr_o) |-> s_done; endproperty
	a_addr: assert property (p_addr) else $error("address moved mid reply");
	property p_baud; $changed(baud_code_o) |-> s_done; endproperty
	a_baud: assert property (p_baud) else $error("baud moved mid reply");
	property p_tx1; tx_valid_o |=> !tx_valid_o; endproperty
	a_tx1: assert property (p_tx1) else $error("byte strobe too long");
	property p_rdy; tx_valid_o |-> $past(tx_ready_i); endproperty
	a_rdy: assert property (p_rdy) else $error("byte sent while busy");
	property p_su; save_user_o |-> !save_fact_o && !restore_o; endproperty
	a_su: assert property (p_su) else $error("save targets clash");
	property p_sf; save_fact_o |=> !save_fact_o; endproperty
	a_sf: assert property (p_sf) else $error("factory save pulse long");
	property p_abn; $fell(cal_abnormal_o) |-> restore_o; endproperty
	a_abn: assert property (p_abn) else $error("abnormal cleared alone");
	property p_idle; tx_done_i |=> !tx_valid_o [*2]; endproperty
	a_idle: assert property (p_idle) else $error("bytes after reply end");
endmodule // mbt_cmd_chk
bind mbt_cmd_top mbt_cmd_chk i_mbt_cmd_chk (.*);

//--- verif/mbt_uart_sink.sv
// Behavioural transmit side of the serial line
`timescale 1ns/1ps
module mbt_uart_sink (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Bytes from the interpreter
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	// Line status
	output logic tx_ready_o,
	output logic tx_done_o
);
	logic [7:0] got[$];
	int busy;
	int idle;
	// one whole character per byte, random shift time
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		tx_done_o <= 1'b0;
		if (!rst_b_i) begin
			busy = 0;
			idle = 0;
		end else if (tx_valid_i) begin
			got.push_back(tx_data_i);
			busy = 2 + $urandom_range(3);
			idle = 8;
		end else if (busy > 0) begin
			busy--;
		end else if (idle > 0) begin
			idle--;
			tx_done_o <= (idle == 1);
		end
		tx_ready_o <= rst_b_i && busy == 0;
	end
endmodule // mbt_uart_sink

//--- verif/mbt_cmd_top_tb.sv
// Self-checking bench of the command interpreter
`timescale 1ns/1ps
module mbt_cmd_top_tb;
	import mbt_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic rx_valid_i = 1'b0;
	logic rx_gap_i = 1'b0;
	logic [7:0] rx_data_i = 8'h0;
	logic [15:0] meas_i, unit_i, ofs, na;
	logic [1:0] dec_places_i;
	mbt_params_s fact_params_i;
	logic tx_ready_i, tx_done_i, tx_valid_o, save_user_o, save_fact_o, restore_o, cal_abnormal_o;
	logic [7:0] tx_data_o, bus_addr_o, ea;
	logic [2:0] baud_code_o;
	logic [2:0] hit = 3'h0;
	int failures = 0;
	int n_compared = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	// Sticky record, pulses are too short to poll
	always @(posedge sys_clk_i) if (rst_b_i) hit <= hit | {restore_o, save_fact_o, save_user_o};
	mbt_cmd_top i_mbt_cmd_top (.*);
	mbt_uart_sink i_mbt_uart_sink (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i),
		.tx_done_o(tx_done_i));
	task automatic close_out;
		if (failures == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [15:0] crc(input logic [7:0] b[8], input int n);
		logic [15:0] c = 16'hFFFF;
		for (int i = 0; i < n; i++) begin
			c ^= {8'h0, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	// One request, then the expected reply or silence
	task automatic xfer(input logic [7:0] a, f, input logic [15:0] r, v, rv, input logic bad = 0);
		logic [7:0] b[8], e[8];
		logic [15:0] c;
		int n, k, q0;
		b = '{a, f, r[15:8], r[7:0], v[15:8], v[7:0], 8'h0, 8'h0};
		c = crc(b, 6) ^ {15'h0, bad};
		b[6] = c[7:0];
		b[7] = c[15:8];
		e = '{a, f, 8'h2, rv[15:8], rv[7:0], 8'h0, 8'h0, 8'h0};
		c = crc(e, 5);
		e[5] = c[7:0];
		e[6] = c[15:8];
		if (f == 8'h6) e = b;
		n = (bad || a != ea) ? 0 : (f == 8'h6 ? 8 : 7);
		q0 = i_mbt_uart_sink.got.size();
		foreach (b[i]) begin
			rx_data_i = b[i];
			rx_valid_i = 1'b1;
			@(posedge sys_clk_i) #1 rx_valid_i = 1'b0;
			@(posedge sys_clk_i) #1;
		end
		rx_gap_i = 1'b1;
		@(posedge sys_clk_i) #1 rx_gap_i = 1'b0;
		for (k = 0; k < 400 && tx_done_i !== 1'b1; k++) @(posedge sys_clk_i) #1;
		if (n > 0 && k == 400) begin
			failures++;
			close_out();
		end
		repeat (3) @(posedge sys_clk_i) #1;
		check("reply length", 16'(i_mbt_uart_sink.got.size() - q0), 16'(n));
		for (k = 0; k < n; k++) check("reply byte", {8'h0, i_mbt_uart_sink.got[q0 + k]}, {8'h0, e[k]});
	endtask
	initial begin
		void'($urandom(31208));
		meas_i = $urandom;
		unit_i = $urandom;
		dec_places_i = $urandom;
		fact_params_i = '{8'($urandom_range(1, 255)), 3'($urandom), 16'($urandom)};
		ofs = $urandom;
		na = $urandom_range(2, 255);
		ea = 8'h1;
		repeat (10) @(posedge sys_clk_i);
		#1 rst_b_i = 1'b1;
		xfer(ea, 8'h3, 16'h0, 16'h1, 16'h1);
		xfer(ea, 8'h3, 16'h3, 16'h1, {14'h0, dec_places_i});
		xfer(ea, 8'h3, 16'h4, 16'h1, meas_i);
		xfer(ea, 8'h6, 16'hC, ofs, 16'h0);
		xfer(ea, 8'h3, 16'h4, 16'h1, meas_i + ofs);
		xfer(ea, 8'h3, 16'hC, 16'h1, ofs);
		xfer(ea, 8'h3, 16'h2, 16'h1, unit_i);
		xfer(ea, 8'h3, 16'h9, 16'h1, 16'h0);
		xfer(ea, 8'h3, 16'h4, 16'h1, meas_i, 1'b1);
		for (int i = 0; i < 8; i++) begin
			xfer(ea, 8'h6, 16'h1, 16'(i), 16'h0);
			check("baud code", {13'h0, baud_code_o}, 16'(i));
		end
		xfer(ea, 8'h3, 16'h1, 16'h1, 16'h7);
		xfer(ea, 8'h6, 16'h0, na, 16'h0);
		ea = na[7:0];
		check("bus address", {8'h0, bus_addr_o}, na);
		xfer(8'h1, 8'h3, 16'h0, 16'h1, 16'h1);
		xfer(ea, 8'h6, 16'hF, 16'h2, 16'h0);
		check("no save pulse", {13'h0, hit}, 16'h0);
		xfer(ea, 8'h6, 16'hF, 16'h0, 16'h0);
		xfer(ea, 8'h6, 16'hF, 16'h1, 16'h0);
		check("save pulses", {13'h0, hit}, 16'h3);
		xfer(ea, 8'h6, 16'h5, ofs, 16'h0);
		check("abnormal flag", {15'h0, cal_abnormal_o}, 16'h1);
		xfer(ea, 8'h3, 16'h4, 16'h1, 16'h8000);
		xfer(ea, 8'h6, 16'h10, 16'h1, 16'h0);
		ea = fact_params_i.addr;
		check("restore", {hit[2], cal_abnormal_o, baud_code_o, bus_addr_o, 3'h0},
			{2'h2, fact_params_i.baud, ea, 3'h0});
		xfer(ea, 8'h3, 16'h0, 16'h1, {8'h0, ea});
		close_out();
	end
endmodule // mbt_cmd_top_tb
